// ### logic/apf_pkg.sv
// Functional notes
// - add two registers, optionally plus carry, one cycle; update Z C N V H.
// - add or subtract immediate on 16-bit pair, two cycles; update Z C N V S.
// - subtract register or immediate from destination, one cycle; update Z C N V H.
// - subtract operand plus carry with borrow, one cycle; update Z C N V H.
// - and, or, exclusive or with register or constant, one cycle; only Z N V.
// - ones invert gives all-ones minus value, one cycle; update Z C N V.
// - twos invert gives zero minus value, one cycle; update Z C N V H.
// - force bits high by or mask, low by and inverted mask; Z N V.
// - increment or decrement by one, one cycle; Z N V only, carry kept.
// - probe ands register with itself, wipe xors it; fill loads ones, flags kept.
// - near goto loads pc plus signed offset plus one, two cycles, flags kept.
// - pointer goto loads pc from Z pointer pair, two cycles, flags kept.
// - calls take three cycles; returns reload pc from stack in four; handler exit sets I.
// - equal skip skips next instruction when registers match; one, two or three cycles.
// - compares subtract only to set Z N V C H, result discarded, one cycle.
// - register bit skip on selected bit clear or set; one to three cycles; flags kept.
// - io bit skip on selected io bit clear or set; one to three cycles; flags kept.
// - flag set branch adds offset plus one when selected flag set; 1 or 2 cycles.
package apf_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_OPA    = 8'h04;
    localparam logic [7:0] OFS_OPB    = 8'h08;
    localparam logic [7:0] OFS_WORD   = 8'h0c;
    localparam logic [7:0] OFS_OFFSET = 8'h10;
    localparam logic [7:0] OFS_PC     = 8'h14;
    localparam logic [7:0] OFS_ZPTR   = 8'h18;
    localparam logic [7:0] OFS_STACK  = 8'h1c;
    localparam logic [7:0] OFS_FLAGS  = 8'h20;
    localparam logic [7:0] OFS_RESULT = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;

    // flag_register bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [11:0] RST_OFFS  = 12'h000;

    // cycle counts
    localparam logic [2:0] CYC_ONE   = 3'h1;
    localparam logic [2:0] CYC_TWO   = 3'h2;
    localparam logic [2:0] CYC_THREE = 3'h3;
    localparam logic [2:0] CYC_FOUR  = 3'h4;

    // pc steps for a skip over one- or two-word instruction
    localparam logic [15:0] PC_STEP1 = 16'h0001;
    localparam logic [15:0] PC_STEP2 = 16'h0002;
    localparam logic [15:0] PC_STEP3 = 16'h0003;

    typedef enum logic [5:0] {
        OP_ADD        = 6'h00,
        OP_ADD_CARRY  = 6'h01,
        OP_SUB        = 6'h02,
        OP_SUB_BORROW = 6'h03,
        OP_CMP        = 6'h04,
        OP_CMP_BORROW = 6'h05,
        OP_AND        = 6'h06,
        OP_OR         = 6'h07,
        OP_XOR        = 6'h08,
        OP_FORCE_LOW  = 6'h09,
        OP_ONES       = 6'h0a,
        OP_TWOS       = 6'h0b,
        OP_INC        = 6'h0c,
        OP_DEC        = 6'h0d,
        OP_PROBE      = 6'h0e,
        OP_WIPE       = 6'h0f,
        OP_FILL       = 6'h10,
        OP_WORD_ADD   = 6'h11,
        OP_WORD_SUB   = 6'h12,
        OP_NEAR_GOTO  = 6'h13,
        OP_PTR_GOTO   = 6'h14,
        OP_NEAR_CALL  = 6'h15,
        OP_PTR_CALL   = 6'h16,
        OP_SUB_EXIT   = 6'h17,
        OP_HAND_EXIT  = 6'h18,
        OP_EQ_SKIP    = 6'h19,
        OP_RBIT_LOW   = 6'h1a,
        OP_RBIT_HIGH  = 6'h1b,
        OP_IOBIT_LOW  = 6'h1c,
        OP_IOBIT_HIGH = 6'h1d,
        OP_FLAG_BR    = 6'h1e
    } apf_op_t;

    localparam logic [5:0] OP_LAST = 6'h1e;

    // control word: op in [5:0], bit select in [8:6], two-word skip in [9]
    typedef struct packed {
        logic       two_word;
        logic [2:0] bit_sel;
        logic [5:0] op;
    } apf_ctrl_t;

    typedef struct packed {
        logic [7:0]  res8;
        logic [15:0] res16;
        logic [7:0]  flags;
        logic        wr8;
        logic        wr16;
    } apf_alu_out_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } apf_state_t;

endpackage

// ### logic/apf_alu.sv
`timescale 1ns/1ps
module apf_alu
    import apf_pkg::*;
(
    // operation and operands
    input  wire apf_op_t      op,
    input  wire logic [7:0]   a,
    input  wire logic [7:0]   b,
    input  wire logic [15:0]  w,
    input  wire logic [7:0]   flags_in,
    // outcome
    output apf_alu_out_t      out
);

    logic        sub;
    logic [7:0]  x;
    logic [7:0]  y;
    logic        c;
    logic [4:0]  lo;
    logic [8:0]  full;
    logic [16:0] wsum;
    logic [7:0]  r;
    logic [7:0]  calc;
    logic [7:0]  mask;

    always_comb begin
        sub  = 1'b0;
        x    = a;
        y    = b;
        c    = 1'b0;
        calc = 8'h00;
        mask = 8'h00;
        r    = 8'h00;
        out.res16 = w;
        out.wr8   = 1'b0;
        out.wr16  = 1'b0;
        case (op)
            OP_ADD_CARRY:                c = flags_in[FLAG_C];
            OP_SUB, OP_CMP:              sub = 1'b1;
            OP_SUB_BORROW, OP_CMP_BORROW: begin
                sub = 1'b1;
                c   = flags_in[FLAG_C];
            end
            OP_INC:                      y = 8'h01;
            OP_DEC: begin
                sub = 1'b1;
                y   = 8'h01;
            end
            OP_TWOS: begin
                sub = 1'b1;
                x   = 8'h00;
                y   = a;
            end
            default:                     c = 1'b0;
        endcase
        lo   = sub ? ({1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, c}) : ({1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, c});
        full = sub ? ({1'b0, x} - {1'b0, y} - {8'h00, c}) : ({1'b0, x} + {1'b0, y} + {8'h00, c});
        // immediate for word ops is six bits wide
        wsum = (op == OP_WORD_SUB) ? ({1'b0, w} - {11'h000, b[5:0]}) : ({1'b0, w} + {11'h000, b[5:0]});
        case (op)
            OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW, OP_CMP, OP_CMP_BORROW, OP_TWOS: begin
                r = full[7:0];
                calc[FLAG_C] = full[8];
                calc[FLAG_H] = lo[4];
                calc[FLAG_V] = sub ? ((x[7] != y[7]) && (r[7] != x[7])) : ((x[7] == y[7]) && (r[7] != x[7]));
                // borrow chains keep zero only if it was already set
                calc[FLAG_Z] = (r == 8'h00) && ((op != OP_SUB_BORROW && op != OP_CMP_BORROW) || flags_in[FLAG_Z]);
                mask = 8'h2f;
                out.wr8 = (op != OP_CMP) && (op != OP_CMP_BORROW);
            end
            OP_INC, OP_DEC: begin
                r = full[7:0];
                calc[FLAG_V] = sub ? ((x[7] != y[7]) && (r[7] != x[7])) : ((x[7] == y[7]) && (r[7] != x[7]));
                calc[FLAG_Z] = (r == 8'h00);
                mask = 8'h0e;
                out.wr8 = 1'b1;
            end
            OP_ONES: begin
                r = ~a;
                calc[FLAG_C] = 1'b1;
                calc[FLAG_Z] = (r == 8'h00);
                mask = 8'h0f;
                out.wr8 = 1'b1;
            end
            OP_AND, OP_OR, OP_XOR, OP_FORCE_LOW, OP_PROBE, OP_WIPE: begin
                case (op)
                    OP_AND:       r = a & b;
                    OP_OR:        r = a | b;
                    OP_XOR:       r = a ^ b;
                    OP_FORCE_LOW: r = a & ~b;
                    OP_PROBE:     r = a & a;
                    default:      r = a ^ a;
                endcase
                calc[FLAG_Z] = (r == 8'h00);
                mask = 8'h0e;
                out.wr8 = 1'b1;
            end
            OP_FILL: begin
                r = 8'hff;
                out.wr8 = 1'b1;
            end
            OP_WORD_ADD, OP_WORD_SUB: begin
                out.res16 = wsum[15:0];
                calc[FLAG_C] = wsum[16];
                calc[FLAG_Z] = (wsum[15:0] == 16'h0000);
                calc[FLAG_V] = (op == OP_WORD_SUB) ? (w[15] && !wsum[15]) : (!w[15] && wsum[15]);
                calc[FLAG_N] = wsum[15];
                calc[FLAG_S] = calc[FLAG_N] ^ calc[FLAG_V];
                mask = 8'h1f;
                out.wr16 = 1'b1;
            end
            default: r = a;
        endcase
        if (op != OP_WORD_ADD && op != OP_WORD_SUB) begin
            calc[FLAG_N] = r[7];
        end
        out.res8 = r;
        out.flags = (flags_in & ~mask) | (calc & mask);
    end

endmodule

// ### logic/apf_core.sv
`timescale 1ns/1ps
module apf_core
    import apf_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // io bit test path
    input  wire logic [7:0]  io_byte,
    // status
    output logic             busy
);

    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr[1:0] == 2'b00) && (addr <= OFS_STATUS);
    endfunction

    function automatic logic is_writable(input logic [7:0] addr);
        is_writable = is_mapped(addr) && (addr != OFS_RESULT) && (addr != OFS_STATUS);
    endfunction

    apf_state_t   state;
    apf_ctrl_t    ctrl;
    apf_op_t      cur_op;
    logic [7:0]   opa;
    logic [7:0]   opb;
    logic [15:0]  word;
    logic [11:0]  offs;
    logic [15:0]  pc;
    logic [15:0]  zptr;
    logic [15:0]  stack;
    logic [7:0]   flags;
    logic [15:0]  result;
    logic [2:0]   cnt;
    logic         take;
    logic         skipped;
    logic [31:0]  rd_word;
    apf_alu_out_t alu_out;

    // apb decode
    wire          setup      = psel & ~penable;
    wire          wr_fire    = psel & penable & pready & pwrite;
    wire          wr_ok      = wr_fire & ~pslverr;
    wire          ctrl_wr    = wr_ok & (paddr == OFS_CTRL);
    wire          op_valid   = (pwdata[5:0] <= OP_LAST);
    wire          wr_err     = pwrite & (~is_writable(paddr) | busy | ((paddr == OFS_CTRL) & ~op_valid));
    wire          next_err   = ~is_mapped(paddr) | wr_err;

    // operation decode from the newly written control word
    wire apf_ctrl_t new_ctrl = apf_ctrl_t'(pwdata[9:0]);
    wire apf_op_t   new_op   = apf_op_t'(new_ctrl.op);
    wire            start    = ctrl_wr;
    wire            commit   = (state == ST_EXEC) && (cnt == CYC_ONE);

    // branch targets
    wire [15:0]   pc_one     = pc + PC_STEP1;
    wire [15:0]   rel_pc     = pc + {{4{offs[11]}}, offs} + PC_STEP1;
    wire [15:0]   skip_pc    = pc + (ctrl.two_word ? PC_STEP3 : PC_STEP2);
    wire [2:0]    skip_cyc   = new_ctrl.two_word ? CYC_THREE : CYC_TWO;

    // skip and branch condition at start
    wire          sel_rbit   = opa[new_ctrl.bit_sel];
    wire          sel_iobit  = io_byte[new_ctrl.bit_sel];
    wire          sel_flag   = flags[new_ctrl.bit_sel];
    wire          next_take  = (new_op == OP_EQ_SKIP)    ? (opa == opb) :
                               (new_op == OP_RBIT_LOW)   ? ~sel_rbit :
                               (new_op == OP_RBIT_HIGH)  ? sel_rbit :
                               (new_op == OP_IOBIT_LOW)  ? ~sel_iobit :
                               (new_op == OP_IOBIT_HIGH) ? sel_iobit :
                               (new_op == OP_FLAG_BR)    ? sel_flag : 1'b0;
    wire          is_skip    = (new_op == OP_EQ_SKIP) | (new_op == OP_RBIT_LOW) | (new_op == OP_RBIT_HIGH) |
                               (new_op == OP_IOBIT_LOW) | (new_op == OP_IOBIT_HIGH);

    wire [2:0]    next_cnt   = is_skip ? (next_take ? skip_cyc : CYC_ONE) :
                               (new_op == OP_FLAG_BR) ? (next_take ? CYC_TWO : CYC_ONE) :
                               ((new_op == OP_WORD_ADD) | (new_op == OP_WORD_SUB) |
                                (new_op == OP_NEAR_GOTO) | (new_op == OP_PTR_GOTO)) ? CYC_TWO :
                               ((new_op == OP_NEAR_CALL) | (new_op == OP_PTR_CALL)) ? CYC_THREE :
                               ((new_op == OP_SUB_EXIT) | (new_op == OP_HAND_EXIT)) ? CYC_FOUR : CYC_ONE;

    wire          is_call    = (cur_op == OP_NEAR_CALL) | (cur_op == OP_PTR_CALL);
    wire [15:0]   next_pc    = ((cur_op == OP_NEAR_GOTO) | (cur_op == OP_NEAR_CALL)) ? rel_pc :
                               ((cur_op == OP_PTR_GOTO) | (cur_op == OP_PTR_CALL)) ? zptr :
                               ((cur_op == OP_SUB_EXIT) | (cur_op == OP_HAND_EXIT)) ? stack :
                               (cur_op == OP_FLAG_BR) ? (take ? rel_pc : pc_one) :
                               ((cur_op >= OP_EQ_SKIP) && take) ? skip_pc : pc_one;

    // handler exit sets the global interrupt flag only
    wire [7:0]    next_flags = (cur_op == OP_HAND_EXIT) ? (flags | (8'h01 << FLAG_I)) : alu_out.flags;

    apf_alu u_alu (
        .op       (cur_op),
        .a        (opa),
        .b        (opb),
        .w        (word),
        .flags_in (flags),
        .out      (alu_out)
    );

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            OFS_CTRL:   rd_word = {22'h000000, ctrl};
            OFS_OPA:    rd_word = {24'h000000, opa};
            OFS_OPB:    rd_word = {24'h000000, opb};
            OFS_WORD:   rd_word = {16'h0000, word};
            OFS_OFFSET: rd_word = {20'h00000, offs};
            OFS_PC:     rd_word = {16'h0000, pc};
            OFS_ZPTR:   rd_word = {16'h0000, zptr};
            OFS_STACK:  rd_word = {16'h0000, stack};
            OFS_FLAGS:  rd_word = {24'h000000, flags};
            OFS_RESULT: rd_word = {16'h0000, result};
            OFS_STATUS: rd_word = {29'h00000000, skipped, take, busy};
            default:    rd_word = 32'h0000_0000;
        endcase
    end

    // apb answer: one wait-free access phase, data captured in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & next_err;
            prdata  <= setup ? rd_word : prdata;
        end
    end

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= ST_IDLE;
            busy    <= 1'b0;
            cnt     <= CYC_ONE;
            cur_op  <= OP_ADD;
            take    <= 1'b0;
            skipped <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state  <= ST_EXEC;
                        busy   <= 1'b1;
                        cnt    <= next_cnt;
                        cur_op <= new_op;
                        take   <= next_take;
                    end
                end
                ST_EXEC: begin
                    if (commit) begin
                        state   <= ST_IDLE;
                        busy    <= 1'b0;
                        skipped <= take & (cur_op != OP_FLAG_BR);
                    end else begin
                        cnt <= cnt - CYC_ONE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    // register file; software writes are refused while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl   <= apf_ctrl_t'(10'h000);
            opa    <= RST_BYTE;
            opb    <= RST_BYTE;
            word   <= RST_WORD;
            offs   <= RST_OFFS;
            pc     <= RST_WORD;
            zptr   <= RST_WORD;
            stack  <= RST_WORD;
            flags  <= RST_BYTE;
            result <= RST_WORD;
        end else if (commit) begin
            pc    <= next_pc;
            flags <= next_flags;
            if (alu_out.wr8) begin
                opa    <= alu_out.res8;
                result <= {8'h00, alu_out.res8};
            end
            if (alu_out.wr16) begin
                word   <= alu_out.res16;
                result <= alu_out.res16;
            end
            if (is_call) begin
                stack <= pc_one;
            end
        end else if (wr_ok) begin
            case (paddr)
                OFS_CTRL:   ctrl  <= new_ctrl;
                OFS_OPA:    opa   <= pwdata[7:0];
                OFS_OPB:    opb   <= pwdata[7:0];
                OFS_WORD:   word  <= pwdata[15:0];
                OFS_OFFSET: offs  <= pwdata[11:0];
                OFS_PC:     pc    <= pwdata[15:0];
                OFS_ZPTR:   zptr  <= pwdata[15:0];
                OFS_STACK:  stack <= pwdata[15:0];
                OFS_FLAGS:  flags <= pwdata[7:0];
                default:    result <= result;
            endcase
        end
    end

    a_add_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        (start && new_op == OP_ADD) |=> busy ##1 !busy)
        else $error("add did not finish in one cycle");

    a_add_result_val: assert property (@(posedge pclk) disable iff (!presetn)
        (commit && cur_op == OP_ADD) |=> (opa == 8'($past(opa) + $past(opb))))
        else $error("add result wrong");

    a_word_two_cyc: assert property (@(posedge pclk) disable iff (!presetn)
        (start && (new_op == OP_WORD_ADD || new_op == OP_WORD_SUB)) |=> busy[*2] ##1 !busy)
        else $error("word op not two cycles");

    a_logic_v_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (commit && (cur_op == OP_AND || cur_op == OP_OR || cur_op == OP_XOR))
        |=> !flags[FLAG_V] && flags[FLAG_C] == $past(flags[FLAG_C]))
        else $error("logic op flags wrong");

    a_inc_keeps_c: assert property (@(posedge pclk) disable iff (!presetn)
        (commit && (cur_op == OP_INC || cur_op == OP_DEC)) |=> $stable(flags[FLAG_C]))
        else $error("increment changed carry");

    a_fill_flag_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (commit && cur_op == OP_FILL) |=> opa == 8'hff && $stable(flags))
        else $error("fill wrong");

    a_near_goto_pc: assert property (@(posedge pclk) disable iff (!presetn)
        (start && new_op == OP_NEAR_GOTO) |-> ##3 (pc == $past(rel_pc, 3)) && $stable(flags))
        else $error("near goto target wrong");

    a_ptr_goto_pc: assert property (@(posedge pclk) disable iff (!presetn)
        (start && new_op == OP_PTR_GOTO) |-> ##3 (pc == $past(zptr, 3)))
        else $error("pointer goto target wrong");

    a_call_three_cyc: assert property (@(posedge pclk) disable iff (!presetn)
        (start && (new_op == OP_NEAR_CALL || new_op == OP_PTR_CALL)) |=> busy[*3] ##1 !busy)
        else $error("call not three cycles");

    a_exit_four_cyc: assert property (@(posedge pclk) disable iff (!presetn)
        (start && new_op == OP_HAND_EXIT) |=> busy[*4] ##1 (!busy && flags[FLAG_I]))
        else $error("handler exit wrong");

    a_skip_two_word: assert property (@(posedge pclk) disable iff (!presetn)
        (start && is_skip && next_take && new_ctrl.two_word) |=> busy[*3] ##1 !busy)
        else $error("two-word skip not three cycles");

    a_cmp_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        (commit && (cur_op == OP_CMP || cur_op == OP_CMP_BORROW)) |=> $stable(opa))
        else $error("compare wrote destination");

    a_branch_untaken: assert property (@(posedge pclk) disable iff (!presetn)
        (start && new_op == OP_FLAG_BR && !next_take) |=> busy ##1 (!busy && pc == $past(pc) + PC_STEP1))
        else $error("untaken branch wrong");

    a_ones_sets_c: assert property (@(posedge pclk) disable iff (!presetn)
        (commit && cur_op == OP_ONES) |=> (opa == ~$past(opa)) && flags[FLAG_C])
        else $error("ones invert wrong");

    a_io_skip_two: assert property (@(posedge pclk) disable iff (!presetn)
        (start && new_op == OP_IOBIT_HIGH && next_take && !new_ctrl.two_word) |=> busy[*2] ##1 !busy)
        else $error("io bit skip not two cycles");

endmodule

// ### verif/apf_core_tb_top.sv
`timescale 1ns/1ps
module apf_core_tb_top
    import apf_pkg::*;
;
    typedef struct packed {
        apf_op_t    op;
        logic [7:0] a, b, fin, res, fout;
    } apf_tb_row_t;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  io_byte = 8'h80;
    logic [31:0] prdata, q, n;
    logic        pready, pslverr, busy, e;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    apf_tb_row_t rows [17];

    apf_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .io_byte(io_byte), .busy(busy));

    always #2.5 pclk = ~pclk;

    // a hang anywhere ends the run as a failure
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request held from setup until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask

    // start one operation and count the cycles busy stays high
    task automatic run(input apf_op_t o, input logic [2:0] s, input logic t, input logic [2:0] cyc);
        wr(OFS_CTRL, {22'h0, t, s, o});
        #1;
        n = 0;
        while (busy === 1'b1) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(n, {29'h0, cyc});
    endtask

    initial begin
        rows = '{'{OP_ADD, 8'h7f, 8'h01, 8'h40, 8'h80, 8'h6c}, '{OP_ADD_CARRY, 8'hff, 8'h00, 8'h01, 8'h00, 8'h23},
            '{OP_SUB, 8'h10, 8'h01, 8'h00, 8'h0f, 8'h20}, '{OP_SUB_BORROW, 8'h01, 8'h00, 8'h03, 8'h00, 8'h02},
            '{OP_CMP, 8'h00, 8'h01, 8'h00, 8'h00, 8'h25}, '{OP_CMP_BORROW, 8'h05, 8'h05, 8'h01, 8'h05, 8'h25},
            '{OP_AND, 8'hf0, 8'h0f, 8'h21, 8'h00, 8'h23}, '{OP_OR, 8'h80, 8'h01, 8'h08, 8'h81, 8'h04},
            '{OP_XOR, 8'hff, 8'h0f, 8'h00, 8'hf0, 8'h04}, '{OP_FORCE_LOW, 8'hff, 8'h0f, 8'h00, 8'hf0, 8'h04},
            '{OP_ONES, 8'h00, 8'h00, 8'h00, 8'hff, 8'h05}, '{OP_TWOS, 8'h80, 8'h00, 8'h00, 8'h80, 8'h0d},
            '{OP_INC, 8'h7f, 8'h00, 8'h01, 8'h80, 8'h0d}, '{OP_DEC, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02},
            '{OP_PROBE, 8'h00, 8'h00, 8'h08, 8'h00, 8'h02}, '{OP_WIPE, 8'h55, 8'h00, 8'h00, 8'h00, 8'h02},
            '{OP_FILL, 8'h12, 8'h00, 8'h3f, 8'hff, 8'h3f}};
        repeat (20) @(posedge pclk);
        chk({busy, pready, pslverr}, 32'h0);
        presetn <= 1'b1;
        rc(OFS_FLAGS, 32'h0);
        rc(OFS_PC, 32'h0);
        foreach (rows[i]) begin
            wr(OFS_FLAGS, {24'h0, rows[i].fin});
            wr(OFS_OPA, {24'h0, rows[i].a});
            wr(OFS_OPB, {24'h0, rows[i].b});
            run(rows[i].op, 3'h0, 1'b0, CYC_ONE);
            rc(OFS_OPA, {24'h0, rows[i].res});
            rc(OFS_FLAGS, {24'h0, rows[i].fout});
        end
        wr(OFS_WORD, 32'hffff);
        wr(OFS_OPB, 32'h1);
        wr(OFS_FLAGS, 32'h0);
        run(OP_WORD_ADD, 3'h0, 1'b0, CYC_TWO);
        rc(OFS_FLAGS, 32'h03);
        run(OP_WORD_SUB, 3'h0, 1'b0, CYC_TWO);
        rc(OFS_WORD, 32'hffff);
        rc(OFS_RESULT, 32'hffff);
        rc(OFS_FLAGS, 32'h15);
        wr(OFS_FLAGS, 32'h5a);
        wr(OFS_PC, 32'h10);
        wr(OFS_OFFSET, 32'hffe);
        run(OP_NEAR_GOTO, 3'h0, 1'b0, CYC_TWO);
        rc(OFS_PC, 32'h0f);
        wr(OFS_ZPTR, 32'h1234);
        run(OP_PTR_GOTO, 3'h0, 1'b0, CYC_TWO);
        rc(OFS_PC, 32'h1234);
        wr(OFS_OFFSET, 32'h005);
        run(OP_NEAR_CALL, 3'h0, 1'b0, CYC_THREE);
        rc(OFS_PC, 32'h123a);
        wr(OFS_ZPTR, 32'h0200);
        run(OP_PTR_CALL, 3'h0, 1'b0, CYC_THREE);
        rc(OFS_PC, 32'h0200);
        rc(OFS_STACK, 32'h123b);
        run(OP_SUB_EXIT, 3'h0, 1'b0, CYC_FOUR);
        rc(OFS_FLAGS, 32'h5a);
        run(OP_HAND_EXIT, 3'h0, 1'b0, CYC_FOUR);
        rc(OFS_PC, 32'h123b);
        rc(OFS_FLAGS, 32'hda);
        wr(OFS_OPA, 32'h33);
        wr(OFS_OPB, 32'h33);
        run(OP_EQ_SKIP, 3'h0, 1'b1, CYC_THREE);
        rc(OFS_STATUS, 32'h6);
        wr(OFS_OPB, 32'h34);
        run(OP_EQ_SKIP, 3'h0, 1'b1, CYC_ONE);
        rc(OFS_PC, 32'h123f);
        wr(OFS_OPA, 32'hfe);
        run(OP_RBIT_LOW, 3'h0, 1'b0, CYC_TWO);
        run(OP_RBIT_HIGH, 3'h0, 1'b0, CYC_ONE);
        rc(OFS_PC, 32'h1242);
        run(OP_IOBIT_HIGH, 3'h7, 1'b0, CYC_TWO);
        run(OP_IOBIT_LOW, 3'h7, 1'b0, CYC_ONE);
        rc(OFS_PC, 32'h1245);
        // low bit seen by the io skip, skipped instruction two words long
        @(posedge pclk);
        io_byte <= 8'h7f;
        run(OP_IOBIT_LOW, 3'h7, 1'b1, CYC_THREE);
        wr(OFS_OFFSET, 32'h010);
        run(OP_FLAG_BR, 3'h1, 1'b0, CYC_TWO);
        run(OP_FLAG_BR, 3'h0, 1'b0, CYC_ONE);
        rc(OFS_PC, 32'h125a);
        rc(OFS_FLAGS, 32'hda);
        // refusals: unmapped, bad op, write while busy
        wr(8'h2c, 32'h1);
        chk({31'h0, e}, 32'h1);
        wr(OFS_CTRL, 32'h1f);
        chk({30'h0, e, busy}, 32'h2);
        wr(OFS_CTRL, {26'h0, OP_NEAR_CALL});
        wr(OFS_OPA, 32'h99);
        chk({31'h0, e}, 32'h1);
        while (busy === 1'b1) @(posedge pclk);
        rc(OFS_OPA, 32'hfe);
        // reset while idle, after the last operation has finished, must clear the program counter again
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk({busy, pready, pslverr}, 32'h0);
        presetn <= 1'b1;
        rc(OFS_PC, 32'h0);
        complete_run();
    end
endmodule
